// file: hdl/rws_pkg.sv
// Purpose: Shared constants for the reset, watchdog and supply-monitor controller
// Assumes: 125 MHz aclk; AXI4-Lite register access with 32-bit data
// Notes:   Register offsets are byte addresses, one aligned word each
package rws_pkg;

  // Timing
  localparam int CLK_PERIOD_NS       = 8;
  localparam int SOFT_RESET_DELAY_NS = 16000;
  localparam int SRESET_CYC          = (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC       = 16;
  localparam logic [11:0] SRESET_CNT    = 12'(SRESET_CYC - 1);
  localparam logic [11:0] RST_PULSE_CNT = 12'(RST_PULSE_CYC - 1);

  // Watchdog division exponents for period codes 0..7
  localparam int WDT_EXP [8] = '{8, 10, 12, 14, 15, 16, 17, 18};

  // Low-supply filter limits in oscillator ticks, minus one
  localparam logic [7:0] LVR_LIM0 = 8'h07;
  localparam logic [7:0] LVR_LIM1 = 8'h1f;
  localparam logic [7:0] LVR_LIM2 = 8'h3f;
  localparam logic [7:0] LVR_LIM3 = 8'h7f;

  // Register offsets
  localparam logic [7:0] OFS_WATCHDOG_CONTROL_REGISTER  = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_SRK   = 8'h08;
  localparam logic [7:0] OFS_SMS   = 8'h0c;
  localparam logic [7:0] OFS_SMW   = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // Field positions
  localparam int WKEY_LSB = 3;
  localparam int FLG_WRF  = 0;
  localparam int FLG_LRF  = 1;
  localparam int FLG_SUPPLY_MONITOR_RESET_FLAG = 2;
  localparam int FLG_SOFTWARE_RESET_FLAG = 3;

  // Reset values
  localparam logic [7:0] WATCHDOG_CONTROL_REGISTER_RST  = 8'h53;
  localparam logic [7:0] SRK_RST   = 8'h55;
  localparam logic [7:0] SMS_RST   = 8'h66;
  localparam logic [1:0] SMW_RST   = 2'h1;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // Key and code values
  localparam logic [4:0] WKEY_A  = 5'h0a;
  localparam logic [4:0] WKEY_B  = 5'h15;
  localparam logic [7:0] SKEY_A  = 8'h55;
  localparam logic [7:0] SKEY_B  = 8'haa;
  localparam logic [7:0] SM_1V7  = 8'h66;
  localparam logic [7:0] SM_1V9  = 8'h55;
  localparam logic [7:0] SM_2V55 = 8'h33;
  localparam logic [7:0] SM_3V15 = 8'h99;
  localparam logic [7:0] SM_3V8  = 8'haa;
  localparam logic [7:0] SM_DIS  = 8'hf0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEQ_RUN   = 3'b001,
    SEQ_DELAY = 3'b010,
    SEQ_RESET = 3'b100
  } rws_seq_t;

endpackage

// file: hdl/rws_wdt_div.sv
// Purpose: Watchdog divider counting low-speed oscillator ticks
// Assumes: tick is a one-cycle pulse per oscillator period, on aclk
// Notes:   Overflow is a one-cycle pulse; clear beats a coinciding tick
`timescale 1ns/10ps
`default_nettype none
module rws_wdt_div
  import rws_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [2:0] sel,
  // Event
  output logic            ovf_ff
);

  logic [17:0] cnt_ff;
  logic [17:0] lim;

  always_comb begin
    lim = 18'((19'h1 << WDT_EXP[sel]) - 19'h1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 18'h0_0000;
    end else if (clear) begin
      cnt_ff <= 18'h0_0000;
    end else if (tick) begin
      cnt_ff <= (cnt_ff >= lim) ? 18'h0_0000 : cnt_ff + 18'h0_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_ff <= 1'b0;
    end else begin
      ovf_ff <= tick && !clear && (cnt_ff >= lim);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_div_clear_zero: assert property (clear |=> cnt_ff == 18'h0_0000 && !ovf_ff)
    else $error("watchdog count not cleared");
  a_div_limit_hit: assert property (ovf_ff |-> $past(cnt_ff) == $past(lim))
    else $error("watchdog overflow at wrong count");

endmodule
`default_nettype wire

// file: hdl/rws_ctrl.sv
// Purpose: Reset sequencer with watchdog keys, soft-reset key and supply monitor
// Assumes: aresetn low is the power-on reset; pins are asynchronous to aclk
// Notes:   Cause flags survive every reset except power-on
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Watchdog runs while key field holds valid pattern
// - Bad watchdog key resets after soft delay
// - Power-on loads first watchdog key pattern
// - Watchdog key fault flag, software clear only
// - Overflow when running: full reset, timeout bit
// - Overflow asleep: timeout bit, program counter reset
// - Key fault, clear or halt clears watchdog
// - Watchdog divides oscillator by power of two
// - Period codes map to 2^8 through 2^18
// - Power-on clears the program counter
// - Power-on sets port registers to ones
// - Valid soft keys idle, others reset later
// - Power-on loads first soft-reset key pattern
// - Soft-reset flag set on reset, software clear
// - Upper flag bits zero; power-on clears flags
// - Supply flags set by hardware, software clear
// - Long low supply while enabled resets device
// - Short low-supply pulses are ignored
// - Width codes select 8, 32, 64, 128 ticks
// - Five threshold codes plus one disable code
// - Bad select code: delayed reset, flag, reload
// - Power-on loads the 1.7 V threshold code
// - Supply resets off in sleep or idle
module rws_ctrl
  import rws_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Processor events
  input  wire logic        watchdog_clear_instruction_instr,
  input  wire logic        halt_instr,
  input  wire logic        low_power_mode,
  // Pins
  input  wire logic        low_speed_internal_osc_clk_in,
  input  wire logic        low_supply_in,
  // Reset outputs
  output logic             dev_rst_n,
  output logic             pc_sp_rst,
  output logic             por_init
);

  logic        low_speed_internal_osc_s1_ff, low_speed_internal_osc_s2_ff, low_speed_internal_osc_d_ff, low_s1_ff, low_s2_ff;
  logic        tick;
  logic [7:0]  watchdog_control_register_ff, srk_ff, sms_ff;
  logic [1:0]  smw_ff;
  logic [3:0]  flags_ff, nxt_flags;
  logic        to_ff, pdf_ff;
  logic        wkey_ok, srk_ok, sms_ok, sm_enabled;
  logic [2:0]  bad_vec, cause_ff, cause_now;
  rws_seq_t    state_ff, nxt_state;
  logic [11:0] cnt_ff, nxt_cnt;
  logic        seq_enter;
  logic        wdt_ovf, wdt_clear, wdt_hard, wdt_soft, hard_req;
  logic [7:0]  lvr_cnt_ff, lvr_lim;
  logic        lvr_req;
  logic        dev_rst_n_ff, pc_sp_rst_ff, por_init_ff;
  logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, rd_data;
  logic        rd_err;
  logic        aw_have_ff, w_have_ff;
  logic [7:0]  awaddr_ff, wdata_ff;
  logic        wstrb0_ff;
  logic        aw_hs, w_hs, ar_hs, do_wr, wr_err;
  logic        wr_watchdog_control_register, wr_flags, wr_srk, wr_sms, wr_smw;

  // Two-stage synchronisers; the second stage and, for the oscillator edge detect, its delayed copy feed logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_speed_internal_osc_s1_ff <= 1'b0;
      low_speed_internal_osc_s2_ff <= 1'b0;
      low_speed_internal_osc_d_ff  <= 1'b0;
      low_s1_ff  <= 1'b0;
      low_s2_ff  <= 1'b0;
    end else begin
      low_speed_internal_osc_s1_ff <= low_speed_internal_osc_clk_in;
      low_speed_internal_osc_s2_ff <= low_speed_internal_osc_s1_ff;
      low_speed_internal_osc_d_ff  <= low_speed_internal_osc_s2_ff;
      low_s1_ff  <= low_supply_in;
      low_s2_ff  <= low_s1_ff;
    end
  end

  assign tick = low_speed_internal_osc_s2_ff && !low_speed_internal_osc_d_ff;

  // Key and code checks
  assign wkey_ok = (watchdog_control_register_ff[7:WKEY_LSB] == WKEY_A) || (watchdog_control_register_ff[7:WKEY_LSB] == WKEY_B);
  assign srk_ok  = (srk_ff == SKEY_A) || (srk_ff == SKEY_B);
  assign sms_ok  = (sms_ff == SM_1V7) || (sms_ff == SM_1V9) || (sms_ff == SM_2V55) ||
                   (sms_ff == SM_3V15) || (sms_ff == SM_3V8) || (sms_ff == SM_DIS);
  assign sm_enabled = sms_ok && (sms_ff != SM_DIS) && !low_power_mode;
  assign bad_vec   = {!srk_ok, !sms_ok, !wkey_ok};
  assign cause_now = cause_ff | bad_vec;

  // Watchdog
  assign wdt_clear = watchdog_clear_instruction_instr || halt_instr || !wkey_ok || (state_ff == SEQ_RESET);

  rws_wdt_div u_wdt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .clear   (wdt_clear),
    .sel     (watchdog_control_register_ff[2:0]),
    .ovf_ff  (wdt_ovf)
  );

  assign wdt_hard = wdt_ovf && !low_power_mode;
  assign wdt_soft = wdt_ovf && low_power_mode;

  // Low-supply filter; any gap in the low level restarts the count
  always_comb begin
    unique case (smw_ff)
      2'h0: lvr_lim = LVR_LIM0;
      2'h1: lvr_lim = LVR_LIM1;
      2'h2: lvr_lim = LVR_LIM2;
      2'h3: lvr_lim = LVR_LIM3;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvr_cnt_ff <= 8'h00;
    end else if (!sm_enabled || !low_s2_ff) begin
      lvr_cnt_ff <= 8'h00;
    end else if (tick && lvr_cnt_ff != lvr_lim) begin
      lvr_cnt_ff <= lvr_cnt_ff + 8'h01;
    end
  end

  assign lvr_req  = sm_enabled && low_s2_ff && tick && (lvr_cnt_ff == lvr_lim);
  assign hard_req = wdt_hard || lvr_req;

  // Reset sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      SEQ_RUN: begin
        if (hard_req) begin
          nxt_state = SEQ_RESET;
          nxt_cnt   = RST_PULSE_CNT;
        end else if (|bad_vec) begin
          nxt_state = SEQ_DELAY;
          nxt_cnt   = SRESET_CNT;
        end
      end
      SEQ_DELAY: begin
        if (hard_req || cnt_ff == 12'h000) begin
          nxt_state = SEQ_RESET;
          nxt_cnt   = RST_PULSE_CNT;
        end else begin
          nxt_cnt = cnt_ff - 12'h001;
        end
      end
      SEQ_RESET: begin
        if (cnt_ff == 12'h000) begin
          nxt_state = SEQ_RUN;
        end else begin
          nxt_cnt = cnt_ff - 12'h001;
        end
      end
    endcase
  end

  assign seq_enter = (state_ff != SEQ_RESET) && (nxt_state == SEQ_RESET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= SEQ_RUN;
      cnt_ff   <= 12'h000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Causes gathered while waiting, dropped once the reset pulse runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_ff <= 3'h0;
    end else if (state_ff == SEQ_RESET) begin
      cause_ff <= 3'h0;
    end else begin
      cause_ff <= cause_now;
    end
  end

  // Device reset held through power-on, released synchronously
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_rst_n_ff <= 1'b0;
      pc_sp_rst_ff <= 1'b0;
      por_init_ff  <= 1'b1;
    end else begin
      dev_rst_n_ff <= (state_ff != SEQ_RESET);
      pc_sp_rst_ff <= wdt_soft && (state_ff == SEQ_RUN);
      por_init_ff  <= 1'b0;
    end
  end

  // Cause flags: writing 0 clears a bit, and a set in the same cycle wins
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_flags) begin
      nxt_flags = flags_ff & wdata_ff[3:0];
    end
    if (seq_enter) begin
      nxt_flags[FLG_WRF]  = flags_ff[FLG_WRF] | cause_now[0];
      nxt_flags[FLG_LRF]  = nxt_flags[FLG_LRF] | cause_now[1];
      nxt_flags[FLG_SUPPLY_MONITOR_RESET_FLAG] = nxt_flags[FLG_SUPPLY_MONITOR_RESET_FLAG] | lvr_req;
      nxt_flags[FLG_SOFTWARE_RESET_FLAG] = nxt_flags[FLG_SOFTWARE_RESET_FLAG] | cause_now[2];
      nxt_flags[FLG_WRF]  = nxt_flags[FLG_WRF] & (wr_flags ? wdata_ff[0] | cause_now[0] : 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Timeout and power-down status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_ff  <= 1'b0;
      pdf_ff <= 1'b0;
    end else if (wdt_soft) begin
      to_ff  <= 1'b1;
      pdf_ff <= 1'b1;
    end else if (wdt_hard) begin
      to_ff <= 1'b1;
    end else if (halt_instr) begin
      to_ff  <= 1'b0;
      pdf_ff <= 1'b1;
    end else if (watchdog_clear_instruction_instr) begin
      to_ff  <= 1'b0;
      pdf_ff <= 1'b0;
    end
  end

  // Control registers; a device reset reloads the watchdog control and soft-reset key registers over any write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_control_register_ff <= WATCHDOG_CONTROL_REGISTER_RST;
    end else if (seq_enter) begin
      watchdog_control_register_ff <= WATCHDOG_CONTROL_REGISTER_RST;
    end else if (wr_watchdog_control_register) begin
      watchdog_control_register_ff <= wdata_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      srk_ff <= SRK_RST;
    end else if (seq_enter) begin
      srk_ff <= SRK_RST;
    end else if (wr_srk) begin
      srk_ff <= wdata_ff;
    end
  end

  // A pure low-supply reset keeps the threshold selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sms_ff <= SMS_RST;
    end else if (seq_enter && (cause_now[1] || wdt_hard)) begin
      sms_ff <= SMS_RST;
    end else if (wr_sms) begin
      sms_ff <= wdata_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smw_ff <= SMW_RST;
    end else if (wr_smw) begin
      smw_ff <= wdata_ff[1:0];
    end
  end

  // AXI4-Lite write channel; address and data may arrive in either order
  assign aw_hs    = s_axi_awvalid && awready_ff;
  assign w_hs     = s_axi_wvalid && wready_ff;
  assign do_wr    = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_watchdog_control_register  = do_wr && wstrb0_ff && (awaddr_ff[7:2] == OFS_WATCHDOG_CONTROL_REGISTER[7:2]);
  assign wr_flags = do_wr && wstrb0_ff && (awaddr_ff[7:2] == OFS_FLAGS[7:2]);
  assign wr_srk   = do_wr && wstrb0_ff && (awaddr_ff[7:2] == OFS_SRK[7:2]);
  assign wr_sms   = do_wr && wstrb0_ff && (awaddr_ff[7:2] == OFS_SMS[7:2]);
  assign wr_smw   = do_wr && wstrb0_ff && (awaddr_ff[7:2] == OFS_SMW[7:2]);
  assign wr_err   = !((awaddr_ff[7:2] <= OFS_SMW[7:2]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 8'h00;
      wstrb0_ff  <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_have_ff <= 1'b0;
      end
      if (w_hs) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_have_ff <= 1'b0;
      end
      awready_ff <= !(aw_hs || (aw_have_ff && !do_wr));
      wready_ff  <= !(w_hs || (w_have_ff && !do_wr));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel; reserved bits read as zero
  assign ar_hs = s_axi_arvalid && arready_ff;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (s_axi_araddr[7:2])
      OFS_WATCHDOG_CONTROL_REGISTER[7:2]:  rd_data[7:0] = watchdog_control_register_ff;
      OFS_FLAGS[7:2]: rd_data[3:0] = flags_ff;
      OFS_SRK[7:2]:   rd_data[7:0] = srk_ff;
      OFS_SMS[7:2]:   rd_data[7:0] = sms_ff;
      OFS_SMW[7:2]:   rd_data[1:0] = smw_ff;
      OFS_STAT[7:2]:  rd_data[3:0] = {sm_enabled, wkey_ok, pdf_ff, to_ff};
      default:        rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_ff  <= 1'b1;
      arready_ff <= 1'b0;
      rdata_ff   <= rd_data;
      rresp_ff   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign dev_rst_n     = dev_rst_n_ff;
  assign pc_sp_rst     = pc_sp_rst_ff;
  assign por_init      = por_init_ff;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_delay_done;
    state_ff == SEQ_DELAY && cnt_ff == 12'h000 && !hard_req;
  endsequence

  sequence s_reset_held;
    ##1 (!dev_rst_n_ff) [*8];
  endsequence

  a_wkey_bad_wait: assert property ((state_ff == SEQ_RUN && !wkey_ok && !hard_req) |=>
    (state_ff == SEQ_DELAY && cnt_ff == SRESET_CNT)) else $error("bad key did not start delay");
  a_por_values: assert property (por_init_ff |-> (watchdog_control_register_ff[7:WKEY_LSB] == WKEY_A &&
    srk_ff == SRK_RST && sms_ff == SMS_RST && flags_ff == FLAGS_RST && !dev_rst_n_ff))
    else $error("power-on values wrong");
  a_wrf_latch: assert property ((s_delay_done and cause_now[0]) |=> flags_ff[FLG_WRF])
    else $error("key fault flag not set");
  a_software_reset_flag_latch: assert property ((s_delay_done and cause_now[2]) |=> flags_ff[FLG_SOFTWARE_RESET_FLAG])
    else $error("soft reset flag not set");
  a_wdt_full_reset: assert property ((wdt_hard && state_ff == SEQ_RUN) |=>
    (state_ff == SEQ_RESET && to_ff) ##1 !dev_rst_n_ff) else $error("overflow reset missing");
  a_wdt_sleep_wake: assert property ((wdt_soft && state_ff == SEQ_RUN) |=>
    (pc_sp_rst_ff && to_ff && pdf_ff && dev_rst_n_ff)) else $error("sleep overflow wrong");
  a_lvr_short_gap: assert property (!low_s2_ff |=> lvr_cnt_ff == 8'h00)
    else $error("low supply filter not restarted");
  a_lvr_reset_flag: assert property ((lvr_req && state_ff == SEQ_RUN) |=>
    (state_ff == SEQ_RESET && flags_ff[FLG_SUPPLY_MONITOR_RESET_FLAG])) else $error("supply reset missing");
  a_sms_fault_reload: assert property ((s_delay_done and cause_now[1]) |=>
    (flags_ff[FLG_LRF] && sms_ff == SMS_RST)) else $error("select fault handling wrong");
  a_lvr_sleep_off: assert property (low_power_mode |=> lvr_cnt_ff == 8'h00)
    else $error("supply monitor active in low power");
  a_reset_pulse_len: assert property (seq_enter |=> s_reset_held)
    else $error("device reset pulse too short");
  a_soft_delay_len: assert property ((state_ff == SEQ_RUN && nxt_state == SEQ_DELAY) |=>
    (state_ff == SEQ_DELAY && dev_rst_n_ff) [*8]) else $error("soft delay cut short");

endmodule
`default_nettype wire

// file: tb/rws_tb.sv
// Purpose: Self-checking bench for the reset, watchdog and supply controller
// Assumes: Register map, keys and delays as declared in rws_pkg
// Notes:   Oscillator ticks every 8 aclk cycles so watchdog runs stay short
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rws_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, watchdog_clear_instruction, halt, lowpwr, low_speed_internal_osc, low_sup;
  logic        low_speed_internal_osc_on, dev_rst_n, pc_sp_rst, por_init;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp, rd_r;
  logic [2:0]  lc = 3'h0;
  int          miscompares, n_tests, n;
  rws_ctrl rws_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .watchdog_clear_instruction_instr(watchdog_clear_instruction), .halt_instr(halt),
    .low_power_mode(lowpwr), .low_speed_internal_osc_clk_in(low_speed_internal_osc), .low_supply_in(low_sup),
    .dev_rst_n(dev_rst_n), .pc_sp_rst(pc_sp_rst), .por_init(por_init));
  always #4 aclk = ~aclk;
  // Oscillator stands still while off, so the watchdog only counts when a test wants it
  always @(posedge aclk) begin
    lc   <= lc + 3'h1;
    low_speed_internal_osc <= low_speed_internal_osc_on & lc[2];
  end
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0000_00, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        rd_r = bresp; bready <= 0;
        break;
      end
    end
    chk("bresp", {30'h0, er}, {30'h0, rd_r});
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er = RESP_OKAY, input logic [31:0] m = 32'hffff_ffff);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        rd_v = rdata; rd_r = rresp; rready <= 0;
        break;
      end
    end
    chk(nm, e, rd_v & m);
    chk({nm, "_resp"}, {30'h0, er}, {30'h0, rd_r});
  endtask
  // Waits for one whole device reset pulse; n is the wait before it began
  task automatic wait_rst(input int lim);
    n = 0;
    while (dev_rst_n !== 1'b0 && n < lim) begin @(posedge aclk); n++; end
    chk("dev_rst_low", 32'h0, {31'h0, dev_rst_n});
    repeat (RST_PULSE_CYC + 4) @(posedge aclk);
    chk("dev_rst_back", 32'h1, {31'h0, dev_rst_n});
  endtask
  task automatic pulse_clr;
    watchdog_clear_instruction <= 1;
    @(posedge aclk);
    watchdog_clear_instruction <= 0;
  endtask
  logic [7:0] f_adr [3] = '{OFS_SRK, OFS_WATCHDOG_CONTROL_REGISTER, OFS_SMS};
  logic [7:0] f_bad [3] = '{8'h12, 8'h03, 8'h11};
  logic [7:0] f_rel [3] = '{SRK_RST, WATCHDOG_CONTROL_REGISTER_RST, SMS_RST};
  int         f_bit [3] = '{FLG_SOFTWARE_RESET_FLAG, FLG_WRF, FLG_LRF};
  logic [7:0] sm_ok [6] = '{SM_1V7, SM_1V9, SM_2V55, SM_3V15, SM_3V8, SM_DIS};
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; watchdog_clear_instruction = 0; halt = 0; lowpwr = 0;
    low_sup = 0; low_speed_internal_osc_on = 0; miscompares = 0; n_tests = 0;
    repeat (10) @(posedge aclk);
    chk("por_init_hold", 32'h1, {31'h0, por_init});
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    chk("por_init_rel", 32'h0, {31'h0, por_init});
    rd_chk("watchdog_control_register_por", OFS_WATCHDOG_CONTROL_REGISTER, 32'h0000_0053);
    rd_chk("flags_por", OFS_FLAGS, 32'h0000_0000);
    rd_chk("srk_por", OFS_SRK, 32'h0000_0055);
    rd_chk("sms_por", OFS_SMS, 32'h0000_0066);
    rd_chk("smw_por", OFS_SMW, 32'h0000_0001);
    rd_chk("stat_por", OFS_STAT, 32'h0000_0004, RESP_OKAY, 32'h0000_0007);
    rd_chk("unmapped", 8'h40, 32'h0000_0000, RESP_SLVERR);
    wr(8'h40, 8'h00, RESP_SLVERR);
    $display("test por values done");
    for (int i = 0; i < 3; i++) begin
      wr(f_adr[i], f_bad[i]);
      wait_rst(SRESET_CYC + 100);
      chk("soft_delay_min", 32'h1, {31'h0, n >= SRESET_CYC - 4});
      rd_chk("fault_flag", OFS_FLAGS, 32'h1 << f_bit[i]);
      rd_chk("fault_reload", f_adr[i], {24'h0, f_rel[i]});
      wr(OFS_FLAGS, 8'h00);
      rd_chk("flag_clear", OFS_FLAGS, 32'h0000_0000);
    end
    $display("test key faults done");
    wr(OFS_SRK, SKEY_B);
    wr(OFS_WATCHDOG_CONTROL_REGISTER, {WKEY_B, 3'h3});
    foreach (sm_ok[k]) wr(OFS_SMS, sm_ok[k]);
    repeat (SRESET_CYC + 200) @(posedge aclk);
    chk("valid_keys_quiet", 32'h1, {31'h0, dev_rst_n});
    rd_chk("valid_flags", OFS_FLAGS, 32'h0000_0000);
    wr(OFS_SMS, SM_1V7);
    $display("test valid keys done");
    wr(OFS_WATCHDOG_CONTROL_REGISTER, {WKEY_A, 3'h0});
    low_speed_internal_osc_on <= 1;
    // 256 ticks of 8 cycles each; clearing every 1000 cycles keeps it alive
    for (int k = 0; k < 4; k++) begin repeat (1000) @(posedge aclk); pulse_clr; end
    chk("clr_keeps_alive", 32'h1, {31'h0, dev_rst_n});
    wait_rst(2 * 256 * 8 + 200);
    chk("wdt_period", 32'h1, {31'h0, n > 256 * 8 - 40});
    rd_chk("to_set", OFS_STAT, 32'h0000_0001, RESP_OKAY, 32'h0000_0003);
    rd_chk("watchdog_control_register_reload", OFS_WATCHDOG_CONTROL_REGISTER, 32'h0000_0053);
    wr(OFS_WATCHDOG_CONTROL_REGISTER, {WKEY_A, 3'h0});
    halt <= 1;
    lowpwr <= 1;
    @(posedge aclk);
    halt <= 0;
    n = 0;
    while (pc_sp_rst !== 1'b1 && n < 2 * 256 * 8 + 200) begin @(posedge aclk); n++; end
    chk("sleep_pc_rst", 32'h1, {31'h0, pc_sp_rst});
    chk("sleep_no_rst", 32'h1, {31'h0, dev_rst_n});
    rd_chk("sleep_to_pdf", OFS_STAT, 32'h0000_0003, RESP_OKAY, 32'h0000_0003);
    low_sup <= 1;
    repeat (400) @(posedge aclk);
    chk("sleep_supply_off", 32'h1, {31'h0, dev_rst_n});
    low_sup <= 0;
    lowpwr <= 0;
    pulse_clr;
    rd_chk("clr_to_pdf", OFS_STAT, 32'h0000_0000, RESP_OKAY, 32'h0000_0003);
    $display("test watchdog done");
    wr(OFS_SMW, 8'h00);
    low_sup <= 1;
    repeat (24) @(posedge aclk);
    low_sup <= 0;
    repeat (200) @(posedge aclk);
    chk("short_low_ignored", 32'h1, {31'h0, dev_rst_n});
    low_sup <= 1;
    wait_rst(8 * 8 + 60);
    low_sup <= 0;
    rd_chk("supply_flag", OFS_FLAGS, 32'h1 << FLG_SUPPLY_MONITOR_RESET_FLAG);
    rd_chk("supply_keeps_sms", OFS_SMS, 32'h0000_0066);
    $display("test supply done");
    tally_and_finish;
  end
  initial begin
    #400_000;
    miscompares++;
    $display("MISMATCH watchdog expected finish seen hang");
    tally_and_finish;
  end
endmodule
`default_nettype wire
